// ### hw/nipc_ctrl.sv
// Purpose: Acknowledge control for nested maskable, non-maskable and
//          software interrupts, with an APB register file.
// Assumes: The sequencer reports each completed instruction with a pulse
//          and takes an acknowledge only between instructions.
// Notes:   Acknowledge is offered only in the cycle after an instruction ends.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/100ps

// Function
// R1 - Nesting maskable needs ack enable set
// R2 - Every acknowledge clears ack enable
// R3 - Enable instruction sets ack enable
// R4 - Nesting uses programmable priority levels
// R5 - Equal or higher priority may nest
// R6 - Refused requests stay pending, served later
// R7 - No maskable nesting inside non-maskable handler
// R8 - High-priority handler admits only high requests
// R9 - Low or software handler admits all
// R10 - Priority flag zero means higher
// R11 - Status word instructions defer acknowledge
// R12 - Control register writes defer acknowledge
// R13 - Break does not defer, clears enable; the code blocks both acknowledges at a break's end
// R14 - Non-maskable still taken during break
// R15 - Priority flag never touches request flags
// R16 - Pick higher priority, then default order
// R17 - Copy source priority into in-service flag
// R18 - Hold-off lasts exactly one instruction
module nipc_ctrl
  import nipc_pkg::*;
(
  input  wire logic        pclk,        // CPU clock.
  input  wire logic        presetn,     // Asynchronous reset, active low.
  input  wire logic        psel,        // APB select.
  input  wire logic        penable,     // APB access phase.
  input  wire logic        pwrite,      // APB write.
  input  wire logic [11:0] paddr,       // APB byte address.
  input  wire logic [31:0] pwdata,      // APB write data.
  output logic      [31:0] prdata,      // APB read data.
  output logic             pready,      // APB ready.
  output logic             pslverr,     // APB error on unmapped address.
  input  wire logic [7:0]  src_event,   // Request pulses from sources.
  input  wire logic        nmi_event,   // Non-maskable request pulse.
  input  wire nipc_step_t  step,        // Instruction completion report.
  output nipc_ack_t        ack,         // Acknowledge to the sequencer.
  output logic             irq          // Level interrupt output.
);

  // Source request, mask and priority flags.
  logic [7:0] req_reg, req_next;
  logic [7:0] mask_reg;
  logic [7:0] prio_reg;
  // Status word flag bits.
  logic       ie_reg, ie_next;
  logic       isp_reg, isp_next;
  // Pending non-maskable request, one deep.
  logic       nmi_pend_reg, nmi_pend_next;
  // Kind of handler running.
  nipc_hnd_t  hnd_reg, hnd_next;
  // Acknowledge hold-off for one instruction.
  logic       hold_reg, hold_next;
  // Sticky interrupt status and mask.
  logic [2:0] stat_reg, stat_next;
  logic [2:0] imask_reg;
  // Registered bus and ack outputs.
  logic [31:0] prdata_next;
  logic        pslverr_next;
  nipc_ack_t   ack_next;
  // Event sources synchronised from pins.
  logic [7:0]  src_s1_reg, src_s2_reg;
  logic        nmi_s1_reg, nmi_s2_reg;

  // Bus strobes and address hits. A write lands, and a read clears the
  // sticky status, only at the edge where the master sees pready high.
  wire acc    = psel & penable;
  wire wr     = acc & pready & pwrite;
  wire rd     = acc & pready & ~pwrite;
  wire h_req  = (paddr == `NIPC_OFF_REQ);
  wire h_mask = (paddr == `NIPC_OFF_MASK);
  wire h_prio = (paddr == `NIPC_OFF_PRIO);
  wire h_psw  = (paddr == `NIPC_OFF_PSW);
  wire h_stat = (paddr == `NIPC_OFF_STAT);
  wire h_irq  = (paddr == `NIPC_OFF_IRQ);
  wire h_imsk = (paddr == `NIPC_OFF_IMASK);
  wire mapped = h_req | h_mask | h_prio | h_psw | h_stat | h_irq | h_imsk;

  // Highest-priority candidate among a set of flags, lowest index first.
  function automatic logic [3:0] pick(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `NIPC_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // Acknowledgeable sources: set and unmasked.
  wire [7:0] cand     = req_reg & ~mask_reg;
  // Higher-level (flag zero) candidates.  [R10]
  wire [7:0] cand_hi  = cand & ~prio_reg;
  wire [3:0] pk_hi    = pick(cand_hi);
  wire [3:0] pk_all   = pick(cand);
  // Prefer the higher programmable level, then default order.  [R16]
  wire [3:0] pk       = pk_hi[3] ? pk_hi : pk_all;
  wire       pk_lo    = prio_reg[pk[2:0]];
  // Admission by programmable level against the in-service flag.
  // A running high handler (isp 0) admits only high requests.  [R4] [R5]
  wire       lvl_ok   = ~pk_lo | isp_reg;                       // [R8] [R9]
  // Maskable admission: enable set, level fits, not inside NMI.
  wire       m_ok     = pk[3] & ie_reg & lvl_ok
                        & (hnd_reg != NIPC_H_NMI);          // [R1] [R7]
  // Non-maskable admission: not while its own handler runs.
  wire       n_ok     = nmi_pend_reg & (hnd_reg != NIPC_H_NMI);
  // A deferring instruction blocks acknowledge at its own end, so the
  // request waits for the next instruction; break is not one, but both
  // acknowledges also skip its end. The hold flag covers bus writes.  [R13] [R14] [R11]
  wire       slot     = step.done & ~hold_reg & ~defer;
  wire       take_n   = slot & n_ok & (step.kind != NIPC_I_BRK);
  wire       take_m   = slot & m_ok & ~n_ok & (step.kind != NIPC_I_BRK);
  // Instructions that defer acknowledge by one instruction.
  wire       defer    = (step.kind == NIPC_I_PSW)
                      | (step.kind == NIPC_I_EI)
                      | (step.kind == NIPC_I_DI)
                      | (step.kind == NIPC_I_RETURN_FROM_INTERRUPT_INSTR)
                      | (step.kind == NIPC_I_RETURN_FROM_BREAK_INSTR);   // [R11]
  // Bus writes to control registers also defer.  [R12]
  wire       reg_wr   = wr & (h_req | h_mask | h_prio | h_psw);
  // Per-source request bit pulses.
  wire [7:0] src_rise = src_s2_reg;

  // Request flags: events set, acknowledge and software clear.
  always_comb begin
    req_next = req_reg;
    if (wr & h_req) begin
      req_next = pwdata[7:0];
    end
    if (take_m) begin
      req_next[pk[2:0]] = 1'b0;
    end
    // Set wins over clear; priority flags play no part here.  [R15]
    req_next = req_next | src_rise;
  end

  // Status word, handler tracking and hold-off.
  always_comb begin
    ie_next   = ie_reg;
    isp_next  = isp_reg;
    hnd_next  = hnd_reg;
    hold_next = hold_reg;
    nmi_pend_next = nmi_pend_reg | nmi_s2_reg;
    if (step.done) begin
      // Hold covers the instruction that wrote, then clears.  [R18]
      hold_next = 1'b0;
      case (step.kind)
        NIPC_I_EI: begin
          ie_next = 1'b1;                                      // [R3]
        end
        NIPC_I_DI: begin
          ie_next = 1'b0;
        end
        NIPC_I_RETURN_FROM_INTERRUPT_INSTR, NIPC_I_RETURN_FROM_BREAK_INSTR: begin
          // Return restores flags; pending requests wait one more
          // instruction because a return defers acknowledge.  [R6]
          ie_next  = step.rest_ie;
          isp_next = step.rest_isp;
          hnd_next = NIPC_H_NONE;
        end
        NIPC_I_BRK: begin
          ie_next  = 1'b0;                                     // [R13]
          hnd_next = NIPC_H_SW;
        end
        default: begin
        end
      endcase
    end
    if (wr & h_psw) begin
      ie_next  = pwdata[`NIPC_PSW_IE];
      isp_next = pwdata[`NIPC_PSW_ISP];
    end
    if (reg_wr) begin
      hold_next = 1'b1;                                        // [R12]
    end
    if (take_n) begin
      ie_next  = 1'b0;                                         // [R2]
      isp_next = 1'b0;
      hnd_next = NIPC_H_NMI;                                   // [R14]
      nmi_pend_next = nmi_s2_reg;
    end else if (take_m) begin
      ie_next  = 1'b0;                                         // [R2]
      isp_next = pk_lo;                                        // [R17]
      hnd_next = NIPC_H_MASK;
    end
  end

  // Sticky status: events set, a read clears, set wins.
  always_comb begin
    stat_next = stat_reg;
    if (rd & h_stat) begin
      stat_next = 3'b000;
    end
    stat_next[`NIPC_EV_MACK] = stat_next[`NIPC_EV_MACK] | take_m;
    stat_next[`NIPC_EV_NACK] = stat_next[`NIPC_EV_NACK] | take_n;
    stat_next[`NIPC_EV_BRK]  = stat_next[`NIPC_EV_BRK]
                             | (step.done & (step.kind == NIPC_I_BRK));
  end

  // Read data selection as an if chain.
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (h_req) begin
      prdata_next[7:0] = req_reg;
    end else if (h_mask) begin
      prdata_next[7:0] = mask_reg;
    end else if (h_prio) begin
      prdata_next[7:0] = prio_reg;
    end else if (h_psw) begin
      prdata_next[`NIPC_PSW_IE]  = ie_reg;
      prdata_next[`NIPC_PSW_ISP] = isp_reg;
    end else if (h_stat) begin
      prdata_next[2:0] = stat_reg;
    end else if (h_irq) begin
      prdata_next[2:0] = imask_reg;
    end else if (h_imsk) begin
      prdata_next[2:0] = imask_reg;
    end
  end

  assign pslverr_next = acc & ~pready & ~mapped;
  assign ack_next = '{valid: take_n | take_m, nmi: take_n, src: pk[2:0]};

  // Pin synchronisers for request pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_s1_reg <= 8'h00;
      src_s2_reg <= 8'h00;
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
    end else begin
      src_s1_reg <= src_event;
      src_s2_reg <= src_s1_reg;
      nmi_s1_reg <= nmi_event;
      nmi_s2_reg <= nmi_s1_reg;
    end
  end

  // Control state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg      <= 8'h00;
      ie_reg       <= 1'b0;
      isp_reg      <= 1'b1;
      hnd_reg      <= NIPC_H_NONE;
      hold_reg     <= 1'b0;
      nmi_pend_reg <= 1'b0;
      stat_reg     <= 3'b000;
    end else begin
      req_reg      <= req_next;
      ie_reg       <= ie_next;
      isp_reg      <= isp_next;
      hnd_reg      <= hnd_next;
      hold_reg     <= hold_next;
      nmi_pend_reg <= nmi_pend_next;
      stat_reg     <= stat_next;
    end
  end

  // Software-written mask and priority registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg  <= `NIPC_MASK_RST;
      prio_reg  <= `NIPC_PRIO_RST;
      imask_reg <= 3'b000;
    end else begin
      if (wr & h_mask) begin
        mask_reg <= pwdata[7:0];
      end
      if (wr & h_prio) begin
        prio_reg <= pwdata[7:0];
      end
      if (wr & (h_imsk | h_irq)) begin
        imask_reg <= pwdata[2:0];
      end
    end
  end

  // Registered outputs: one wait state per APB access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      ack     <= '0;
      irq     <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      prdata  <= prdata_next;
      pslverr <= pslverr_next;
      ack     <= ack_next;
      irq     <= |(stat_next & imask_reg);
    end
  end

endmodule

// ### hw/nipc_defines.svh
// Purpose: Named constants for the nested interrupt priority controller.
// Assumes: APB register map with one 32-bit word per register.
// Notes:   Offsets are byte addresses; reset values follow the hardware.
`ifndef NIPC_DEFINES_SVH
`define NIPC_DEFINES_SVH

// Number of maskable sources, lowest index has highest default priority.
`define NIPC_NSRC       8
// Register byte offsets.
`define NIPC_OFF_REQ    12'h000
`define NIPC_OFF_MASK   12'h004
`define NIPC_OFF_PRIO   12'h008
`define NIPC_OFF_PSW    12'h00c
`define NIPC_OFF_STAT   12'h010
`define NIPC_OFF_IRQ    12'h014
`define NIPC_OFF_IMASK  12'h018
// Reset values.
`define NIPC_MASK_RST   8'hff
`define NIPC_PRIO_RST   8'hff
// Program status word bit positions.
`define NIPC_PSW_IE     7
`define NIPC_PSW_ISP    1
`define NIPC_PSW_RST    8'h02
// Interrupt status bits.
`define NIPC_EV_MACK    0
`define NIPC_EV_NACK    1
`define NIPC_EV_BRK     2
`define NIPC_NEV        3

`endif

// ### hw/nipc_pkg.sv
// Purpose: Types shared by the nested interrupt priority controller.
// Assumes: Included constants header is on the include path.
// Notes:   Instruction classes come from the CPU sequencer each step.
`include "nipc_defines.svh"

package nipc_pkg;

  // Class of the instruction that completes in a sequencer step.
  typedef enum logic [2:0] {
    NIPC_I_PLAIN  = 3'b000,  // Ordinary instruction.
    NIPC_I_PSW    = 3'b001,  // Touches the status word or control regs.
    NIPC_I_EI     = 3'b010,  // Enable interrupts.
    NIPC_I_DI     = 3'b011,  // Disable interrupts.
    NIPC_I_RETURN_FROM_INTERRUPT_INSTR   = 3'b100,  // Return from interrupt.
    NIPC_I_RETURN_FROM_BREAK_INSTR   = 3'b101,  // Return from break.
    NIPC_I_BRK    = 3'b110   // Software break.
  } nipc_instr_t;

  // Instruction completion report from the sequencer.
  typedef struct packed {
    logic        done;       // One-cycle pulse: an instruction completed.
    nipc_instr_t kind;       // Its class.
    logic        rest_isp;   // Status word IN_SERVICE_PRIORITY_FLAG restored by a return.
    logic        rest_ie;    // Status word IE restored by a return.
  } nipc_step_t;

  // Acknowledge report to the sequencer.
  typedef struct packed {
    logic       valid;       // One-cycle pulse: take this interrupt.
    logic       nmi;         // The taken request is non-maskable.
    logic [2:0] src;         // Index of the maskable source.
  } nipc_ack_t;

  // Kind of handler currently running.
  typedef enum logic [1:0] {
    NIPC_H_NONE = 2'b00,
    NIPC_H_MASK = 2'b01,
    NIPC_H_NMI  = 2'b10,
    NIPC_H_SW   = 2'b11
  } nipc_hnd_t;

endpackage

// ### tb/nipc_chk_properties.sv
// Purpose: Port-level checks of acknowledge timing and bus answers.
// Assumes: One clock domain, reset active low.
// Notes:   Sees only the ports of the controller.
`timescale 1ns/100ps
module nipc_chk
  import nipc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  src_event,
  input wire logic        nmi_event,
  input wire nipc_step_t  step,
  input wire nipc_ack_t   ack,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic since_ack_reg; // High from an acknowledge until the next step.
  // Tracks whether the enable was just cleared by an acknowledge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_ack_reg <= 1'b0;
    else if (ack.valid)
      since_ack_reg <= 1'b1;
    else if (step.done)
      since_ack_reg <= 1'b0;
  end
  sequence s_defer;
    step.done && step.kind inside {NIPC_I_PSW, NIPC_I_EI, NIPC_I_DI,
                                   NIPC_I_RETURN_FROM_INTERRUPT_INSTR, NIPC_I_RETURN_FROM_BREAK_INSTR};
  endsequence
  sequence s_first_step;
    step.done && since_ack_reg;
  endsequence
  property p_defer;
    s_defer |=> !ack.valid;
  endproperty
  property p_brk;
    step.done && step.kind == NIPC_I_BRK |=> !ack.valid;
  endproperty
  property p_ie_clear;
    s_first_step |=> !(ack.valid && !ack.nmi);
  endproperty
  property p_ack_at_end;
    ack.valid |-> $past(step.done);
  endproperty
  property p_ack_pulse;
    ack.valid |=> !ack.valid;
  endproperty
  property p_one_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_defer: assert property (p_defer)
    else $error("acknowledge after a deferring step");
  a_brk: assert property (p_brk)
    else $error("acknowledge after a break step");
  a_ie_clear: assert property (p_ie_clear)
    else $error("maskable acknowledge right after an acknowledge");
  a_ack_at_end: assert property (p_ack_at_end)
    else $error("acknowledge without an instruction end");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not after one wait state");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("bus error without ready");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
endmodule

bind nipc_ctrl nipc_chk i_nipc_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_event(src_event), .nmi_event(nmi_event), .step(step), .ack(ack),
  .irq(irq));

// ### tb/nipc_seq_model.sv
// Purpose: Instruction sequencer and request sources facing the block.
// Assumes: Steps are at least three cycles apart.
// Notes:   Drives by non-blocking assignment just after an edge.
`timescale 1ns/100ps
module nipc_seq_model
  import nipc_pkg::*;
(
  input  wire logic       pclk,
  input  wire nipc_ack_t  ack,
  output nipc_step_t      step,
  output logic      [7:0] src_event,
  output logic            nmi_event
);
  nipc_ack_t got; // Acknowledge seen in the cycle after a step.
  initial begin
    step = '0;
    src_event = '0;
    nmi_event = 1'b0;
  end
  // Completes one instruction and samples the answer one cycle later.
  task automatic exec(input nipc_instr_t k, input logic ri, input logic re);
    @(posedge pclk);
    step <= '{1'b1, k, ri, re};
    @(posedge pclk);
    step <= '0;
    @(posedge pclk);
    got = ack;
  endtask
  // Pulses sources, then lets the input synchronisers settle.
  task automatic raise(input logic [7:0] s, input logic n);
    @(posedge pclk);
    src_event <= s;
    nmi_event <= n;
    @(posedge pclk);
    src_event <= '0;
    nmi_event <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ### tb/tb.sv
// Purpose: Steps the controller through nesting, hold and break cases.
// Assumes: Answers come one cycle after each instruction end.
// Notes:   Priority e9 makes sources 1, 2 and 4 high priority.
`timescale 1ns/100ps
`include "nipc_defines.svh"
module tb;
  import nipc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        nmi_event, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  src_event;
  nipc_step_t  step;
  nipc_ack_t   ack;
  int          err_total, checked;
  nipc_ctrl i_nipc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .nmi_event(nmi_event), .step(step), .ack(ack),
    .irq(irq));
  nipc_seq_model i_nipc_seq_model (.pclk(pclk), .ack(ack), .step(step),
    .src_event(src_event), .nmi_event(nmi_event));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus transfer; read data and error are kept in rd and er.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Runs one instruction; e is {valid, nmi, src} or zero for none.
  task automatic stp(input nipc_instr_t k, input logic [1:0] r,
                     input logic [4:0] e);
    logic [4:0] m;
    m = e[3] ? 5'h18 : (e[4] ? 5'h1f : 5'h10);
    i_nipc_seq_model.exec(k, r[1], r[0]);
    chk(32'(i_nipc_seq_model.got & m), 32'(e));
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    err_total = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `NIPC_OFF_PRIO, 32'h0);
    chk(rd, 32'hff);
    apb(1'b0, `NIPC_OFF_PSW, 32'h0);
    chk(rd, 32'h02);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `NIPC_OFF_MASK, 32'h0);
    apb(1'b1, `NIPC_OFF_PRIO, 32'he9);
    apb(1'b1, `NIPC_OFF_IMASK, 32'h1);
    apb(1'b1, `NIPC_OFF_PSW, 32'h80);
    i_nipc_seq_model.raise(8'h11, 1'b0);
    stp(NIPC_I_PLAIN, 2'b00, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h14);
    apb(1'b0, `NIPC_OFF_PSW, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irq), 32'h1);
    apb(1'b1, `NIPC_OFF_IMASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b0, `NIPC_OFF_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `NIPC_OFF_STAT, 32'h0);
    chk(rd, 32'h0);
    stp(NIPC_I_EI, 2'b00, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h00);
    i_nipc_seq_model.raise(8'h04, 1'b0);
    stp(NIPC_I_PLAIN, 2'b00, 5'h12);
    stp(NIPC_I_RETURN_FROM_INTERRUPT_INSTR, 2'b01, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h00);
    stp(NIPC_I_RETURN_FROM_INTERRUPT_INSTR, 2'b11, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h10);
    i_nipc_seq_model.raise(8'h20, 1'b0);
    stp(NIPC_I_PLAIN, 2'b00, 5'h00);
    stp(NIPC_I_EI, 2'b00, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h15);
    i_nipc_seq_model.raise(8'hc0, 1'b0);
    stp(NIPC_I_EI, 2'b00, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h16);
    stp(NIPC_I_EI, 2'b00, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h17);
    i_nipc_seq_model.raise(8'h08, 1'b1);
    stp(NIPC_I_PSW, 2'b00, 5'h00);
    stp(NIPC_I_BRK, 2'b00, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h18);
    stp(NIPC_I_EI, 2'b00, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h00);
    stp(NIPC_I_DI, 2'b00, 5'h00);
    apb(1'b0, `NIPC_OFF_REQ, 32'h0);
    chk(rd, 32'h08);
    apb(1'b0, `NIPC_OFF_STAT, 32'h0);
    chk(rd, 32'h7);
    stp(NIPC_I_RETURN_FROM_INTERRUPT_INSTR, 2'b11, 5'h00);
    stp(NIPC_I_PLAIN, 2'b00, 5'h13);
    stp(NIPC_I_RETURN_FROM_BREAK_INSTR, 2'b11, 5'h00);
    give_verdict();
  end
endmodule
